// file: src/msh_ctrl.sv
// Motor stop and hold control top
`timescale 1ns/100ps
`include "msh_defines.svh"
module msh_ctrl
    import msh_pkg::*;
#(
    parameter int unsigned TENTH_CYC = `MSH_TENTH_S_CYC
)(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Run inputs
    input  wire logic        i_start_input,       // 3-wire start, level
    input  wire logic        i_run_direction_input, // 3-wire dir / 2-wire reverse
    input  wire logic        i_forward_run_input, // 2-wire forward
    // Settings
    input  wire logic [15:0] i_speed_cmd,         // Commanded speed r/min
    input  wire logic [15:0] i_meas_speed,        // Measured speed r/min
    input  wire logic [15:0] i_band_width,        // Detection width r/min
    input  wire logic [15:0] i_acc_step,          // Accel step per cycle
    input  wire logic [15:0] i_dec_step,          // Decel step per cycle
    input  wire msh_filt_e   i_filt,              // Softening filter
    input  wire msh_stop_e   i_stop_mode,         // Stop method
    input  wire logic        i_dir_ccw,           // Direction setting
    input  wire logic        i_two_wire,          // 2-wire mode select
    input  wire logic        i_hold_en,           // Load holding select
    input  wire logic [7:0]  i_hold_trq_set,      // -1 or 0..50 %
    input  wire logic [7:0]  i_op_trq_lim,        // Operation data limit %
    input  wire logic [15:0] i_shaft_dev_deg,     // Shaft deviation degrees
    input  wire logic        i_coasting,          // Free-run slower than ramp
    input  wire logic        i_overload,          // Overload condition
    input  wire logic [7:0]  i_ovl_tenths,        // Overload time, tenths s
    input  wire logic        i_alarm_ext,         // Other alarms
    input  wire logic        i_configure,         // Configure command pulse
    // Outputs
    output logic             o_speed_reached_output,
    output msh_drive_s       o_drive,
    output logic             o_alarm
);
    msh_cfg_s    cfg_ff;       // Settings applied at configure
    msh_filt_e   filt_ff;      // Filter applied after stop
    logic        reach_ff;     // Speed reached flag
    logic        alarm_ff;
    msh_drive_s  drv_ff;
    msh_drive_s  nxt_drv;
    logic [15:0] ramp_speed;
    logic        ovl_exp;
    // Run decode per input scheme
    wire run3    = i_start_input;
    wire run2    = i_forward_run_input | i_run_direction_input;
    wire run     = cfg_ff.two_wire ? run2 : run3;
    // Direction input selects setting or its opposite
    wire dir_on  = cfg_ff.two_wire ? i_forward_run_input : i_run_direction_input;
    wire dir     = dir_on ? cfg_ff.dir_ccw : ~cfg_ff.dir_ccw;
    wire running = run & ~alarm_ff;
    wire stopped = (ramp_speed == 16'h0000) && !running;
    // Width clamped to 1..400 and applied live
    wire [15:0] wid = (i_band_width < `MSH_BAND_MIN) ? `MSH_BAND_MIN :
                      (i_band_width > `MSH_BAND_MAX) ? `MSH_BAND_MAX : i_band_width;
    wire [16:0] lo  = {1'b0, i_speed_cmd} - {1'b0, wid};
    wire [16:0] hi  = {1'b0, i_speed_cmd} + {1'b0, wid};
    wire in_band = ({1'b0, i_meas_speed} <= hi) &&
                   (lo[16] || {1'b0, i_meas_speed} >= lo);
    // Holding limit selection
    wire [7:0] follow = (i_op_trq_lim > `MSH_HOLD_TRQ_MAX) ? `MSH_HOLD_TRQ_MAX
                                                            : i_op_trq_lim;
    wire [7:0] direct = (i_hold_trq_set > `MSH_HOLD_TRQ_MAX) ? `MSH_HOLD_TRQ_MAX
                                                              : i_hold_trq_set;
    wire [7:0] hold_lim = (i_hold_trq_set == `MSH_HOLD_TRQ_FOLLOW) ? follow : direct;
    wire hold_req = cfg_ff.hold_en && stopped && !alarm_ff &&
                    (i_shaft_dev_deg >= `MSH_HOLD_ANGLE_DEG);

    // Ramp generator with softening filter
    msh_ramp u_ramp (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_target  (running ? i_speed_cmd : 16'h0000),
        .i_step_up (i_acc_step),
        .i_step_dn (i_dec_step),
        .i_filt    (filt_ff),
        .o_speed   (ramp_speed)
    );
    // Overload detection timer
    msh_timer #(.TENTH_CYC(TENTH_CYC)) u_timer (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_active  (i_overload),
        .i_limit   (i_ovl_tenths),
        .o_expired (ovl_exp)
    );

    // Drive command assembly
    always_comb begin
        nxt_drv          = '0;
        nxt_drv.run      = running || ramp_speed != 16'h0000;
        nxt_drv.dir_ccw  = drv_ff.run ? drv_ff.dir_ccw : dir;
        if (running)
            nxt_drv.dir_ccw = dir;
        nxt_drv.speed    = ramp_speed;
        unique case (i_stop_mode)
            MSH_STOP1: nxt_drv.regen_ret = 1'b0;
            MSH_STOP3: nxt_drv.regen_ret = !running;
            MSH_STOP2: nxt_drv.coast = !running && i_coasting && !alarm_ff;
            default:   nxt_drv.regen_ret = 1'b0;
        endcase
        if (nxt_drv.coast)
            nxt_drv.speed = 16'h0000;
        nxt_drv.hold     = hold_req;
        nxt_drv.hold_trq = hold_req ? hold_lim : 8'h00;
    end

    // Settings capture and status registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_ff   <= '0;
            filt_ff  <= MSH_FILT_OFF;
            reach_ff <= 1'b0;
            alarm_ff <= 1'b0;
            drv_ff   <= '0;
        end else begin
            if (i_configure)
                cfg_ff <= '{dir_ccw: i_dir_ccw, hold_en: i_hold_en,
                           two_wire: i_two_wire};
            if (stopped)
                filt_ff <= i_filt;
            reach_ff <= running && in_band;
            alarm_ff <= ovl_exp | i_alarm_ext;
            drv_ff   <= nxt_drv;
        end
    end
    assign o_speed_reached_output = reach_ff;
    assign o_drive                = drv_ff;
    assign o_alarm                = alarm_ff;

    // Checks
    property p_reach;
        @(posedge i_clk) disable iff (!i_rstn)
        (running && in_band) |=> o_speed_reached_output;
    endproperty
    a_reach: assert property (p_reach) else $error("speed reached missing");
    property p_reach_off;
        @(posedge i_clk) disable iff (!i_rstn)
        !in_band |=> !o_speed_reached_output;
    endproperty
    a_reach_off: assert property (p_reach_off) else $error("speed reached stuck");
    property p_hold_alarm;
        @(posedge i_clk) disable iff (!i_rstn)
        alarm_ff |=> !o_drive.hold;
    endproperty
    a_hold_alarm: assert property (p_hold_alarm) else $error("hold under alarm");
    property p_hold_max;
        @(posedge i_clk) disable iff (!i_rstn)
        o_drive.hold_trq <= `MSH_HOLD_TRQ_MAX;
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("hold torque over 50");
    property p_hold_dis;
        @(posedge i_clk) disable iff (!i_rstn)
        !cfg_ff.hold_en |=> !o_drive.hold;
    endproperty
    a_hold_dis: assert property (p_hold_dis) else $error("hold while disabled");
    property p_hold_ang;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_shaft_dev_deg < `MSH_HOLD_ANGLE_DEG) |=> !o_drive.hold;
    endproperty
    a_hold_ang: assert property (p_hold_ang) else $error("hold below angle");
    property p_regen1;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_stop_mode == MSH_STOP1) |=> !o_drive.regen_ret;
    endproperty
    a_regen1: assert property (p_regen1) else $error("stop1 returned energy");
    property p_cfg;
        @(posedge i_clk) disable iff (!i_rstn)
        !i_configure |=> $stable(cfg_ff);
    endproperty
    a_cfg: assert property (p_cfg) else $error("setting changed without configure");
    // Idle never reports the speed reached
    property p_reach_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        !running |=> !o_speed_reached_output;
    endproperty
    a_reach_idle: assert property (p_reach_idle) else $error("reach while idle");
    property p_reach_exact;
        @(posedge i_clk) disable iff (!i_rstn)
        (running && i_meas_speed == i_speed_cmd) |=> o_speed_reached_output;
    endproperty
    a_reach_exact: assert property (p_reach_exact) else $error("no reach at target");
    // Width never opens past its ceiling, whatever is set
    property p_reach_clamp;
        @(posedge i_clk) disable iff (!i_rstn)
        ({1'b0, i_meas_speed} > {1'b0, i_speed_cmd} + 17'(`MSH_BAND_MAX))
            |=> !o_speed_reached_output;
    endproperty
    a_reach_clamp: assert property (p_reach_clamp) else $error("width not clamped");
    // Holding only at standstill
    property p_hold_run;
        @(posedge i_clk) disable iff (!i_rstn)
        running |=> !o_drive.hold;
    endproperty
    a_hold_run: assert property (p_hold_run) else $error("hold while running");
    property p_hold_moving;
        @(posedge i_clk) disable iff (!i_rstn)
        (ramp_speed != 16'h0000) |=> !o_drive.hold;
    endproperty
    a_hold_moving: assert property (p_hold_moving) else $error("hold while moving");
    // Enabled, stopped, unalarmed and pushed far enough
    sequence s_hold_ready;
        cfg_ff.hold_en && stopped && !alarm_ff && (i_shaft_dev_deg >= `MSH_HOLD_ANGLE_DEG);
    endsequence
    property p_hold_on;
        @(posedge i_clk) disable iff (!i_rstn)
        s_hold_ready |=> o_drive.hold;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("hold not applied");
    // Follow mode takes the operation data limit
    property p_hold_follow;
        @(posedge i_clk) disable iff (!i_rstn)
        (hold_req && i_hold_trq_set == `MSH_HOLD_TRQ_FOLLOW && i_op_trq_lim <= `MSH_HOLD_TRQ_MAX)
            |=> (o_drive.hold_trq == $past(i_op_trq_lim));
    endproperty
    a_hold_follow: assert property (p_hold_follow) else $error("follow limit lost");
    property p_hold_clamp;
        @(posedge i_clk) disable iff (!i_rstn)
        (hold_req && i_hold_trq_set == `MSH_HOLD_TRQ_FOLLOW && i_op_trq_lim > `MSH_HOLD_TRQ_MAX)
            |=> (o_drive.hold_trq == `MSH_HOLD_TRQ_MAX);
    endproperty
    a_hold_clamp: assert property (p_hold_clamp) else $error("hold not clamped");
    property p_hold_direct;
        @(posedge i_clk) disable iff (!i_rstn)
        (hold_req && i_hold_trq_set <= `MSH_HOLD_TRQ_MAX)
            |=> (o_drive.hold_trq == $past(i_hold_trq_set));
    endproperty
    a_hold_direct: assert property (p_hold_direct) else $error("direct limit lost");
    // No torque figure is left standing once holding drops
    property p_hold_zero;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_drive.hold |-> (o_drive.hold_trq == 8'h00);
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("torque without hold");
    property p_regen3;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_stop_mode == MSH_STOP3 && !running) |=> o_drive.regen_ret;
    endproperty
    a_regen3: assert property (p_regen3) else $error("stop3 kept energy");
    property p_regen_run;
        @(posedge i_clk) disable iff (!i_rstn)
        running |=> !o_drive.regen_ret;
    endproperty
    a_regen_run: assert property (p_regen_run) else $error("energy returned in run");
    // Free run only when it is the slower way to stop
    sequence s_coast_ready;
        (i_stop_mode == MSH_STOP2) && !running && i_coasting && !alarm_ff;
    endsequence
    property p_coast2;
        @(posedge i_clk) disable iff (!i_rstn)
        s_coast_ready |=> (o_drive.coast && o_drive.speed == 16'h0000);
    endproperty
    a_coast2: assert property (p_coast2) else $error("stop2 did not coast");
    property p_coast_ramp;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_stop_mode == MSH_STOP2 && !i_coasting) |=> !o_drive.coast;
    endproperty
    a_coast_ramp: assert property (p_coast_ramp) else $error("coast beat ramp");
    property p_coast_other;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_stop_mode != MSH_STOP2) |=> !o_drive.coast;
    endproperty
    a_coast_other: assert property (p_coast_other) else $error("coast outside stop2");
    // An asserted 3-wire direction input or 2-wire forward input follows the direction setting
    property p_dir3;
        @(posedge i_clk) disable iff (!i_rstn)
        (running && !cfg_ff.two_wire && i_run_direction_input)
            |=> (o_drive.dir_ccw == $past(cfg_ff.dir_ccw));
    endproperty
    a_dir3: assert property (p_dir3) else $error("3-wire direction");
    property p_dir2;
        @(posedge i_clk) disable iff (!i_rstn)
        (running && cfg_ff.two_wire && i_forward_run_input)
            |=> (o_drive.dir_ccw == $past(cfg_ff.dir_ccw));
    endproperty
    a_dir2: assert property (p_dir2) else $error("2-wire direction");
    // Idle inputs of the chosen scheme leave the motor off
    property p_run3;
        @(posedge i_clk) disable iff (!i_rstn)
        (!cfg_ff.two_wire && !i_start_input && ramp_speed == 16'h0000) |=> !o_drive.run;
    endproperty
    a_run3: assert property (p_run3) else $error("3-wire ran idle");
    property p_run2;
        @(posedge i_clk) disable iff (!i_rstn)
        (cfg_ff.two_wire && !i_forward_run_input && !i_run_direction_input &&
         ramp_speed == 16'h0000) |=> !o_drive.run;
    endproperty
    a_run2: assert property (p_run2) else $error("2-wire ran idle");
    property p_run_go;
        @(posedge i_clk) disable iff (!i_rstn)
        running |=> o_drive.run;
    endproperty
    a_run_go: assert property (p_run_go) else $error("run not driven");
    // Filter choice moves only at standstill
    property p_filt_keep;
        @(posedge i_clk) disable iff (!i_rstn)
        !stopped |=> $stable(filt_ff);
    endproperty
    a_filt_keep: assert property (p_filt_keep) else $error("filter changed in run");
    property p_filt_take;
        @(posedge i_clk) disable iff (!i_rstn)
        stopped |=> (filt_ff == $past(i_filt));
    endproperty
    a_filt_take: assert property (p_filt_take) else $error("filter not taken");
    // Overload expiry raises the alarm a cycle later
    property p_ovl_alarm;
        @(posedge i_clk) disable iff (!i_rstn)
        ovl_exp |=> o_alarm;
    endproperty
    a_ovl_alarm: assert property (p_ovl_alarm) else $error("overload not alarmed");
    property p_ovl_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
        !i_overload |=> !ovl_exp;
    endproperty
    a_ovl_quiet: assert property (p_ovl_quiet) else $error("overload without cause");
endmodule

// file: common/msh_defines.svh
// Constants for the motor stop and hold control block
// Overview of operation
// - Speed reached when speed within width band
// - Width 1 to 400 r/min, default 200
// - Hold select 1 enables standstill holding torque
// - Holding force starts after about 15 degrees
// - Hold limit -1 uses operation data limit
// - Holding torque clamped to at most 50%
// - Hold limit 0 to 50 applied directly
// - Alarm removes holding force
// - Stop method 1 burns regeneration internally
// - Stop method 3 returns regeneration to supply
// - Stop method 2 coasts, slower ramp wins
// - Softening filter smooths ramps, longer times
// - Direction setting maps run input to shaft
// - Run inputs selectable 3-wire or 2-wire
// - Overload time 0.1 to 10.0 s, default 10.0
// - Filter after stop; direction, hold after configure
`ifndef MSH_DEFINES_SVH
`define MSH_DEFINES_SVH
`define MSH_BAND_MIN         16'h0001
`define MSH_BAND_MAX         16'h0190
`define MSH_BAND_DEF         16'h00C8
`define MSH_HOLD_ANGLE_DEG   16'h000F
`define MSH_HOLD_TRQ_MAX     8'h32
`define MSH_HOLD_TRQ_FOLLOW  8'hFF
`define MSH_OVL_TENTHS_MIN   8'h01
`define MSH_OVL_TENTHS_MAX   8'h64
`define MSH_OVL_TENTHS_DEF   8'h64
`define MSH_CLK_HZ           32'h0262_5A00
`define MSH_TENTH_S_CYC      (`MSH_CLK_HZ / 32'h0000_000A)
`endif

// file: common/msh_pkg.sv
// Types shared by the motor stop and hold control block
package msh_pkg;
    // Deceleration stop methods
    typedef enum logic [1:0] {MSH_STOP1, MSH_STOP2, MSH_STOP3} msh_stop_e;
    // Softening filter choices
    typedef enum logic [1:0] {MSH_FILT_OFF, MSH_FILT1, MSH_FILT2} msh_filt_e;
    // Motor drive command
    typedef struct packed {
        logic        run;       // Motor commanded to turn
        logic        dir_ccw;   // Shaft direction
        logic [15:0] speed;     // Ramped speed target r/min
        logic        regen_ret; // Return regeneration to supply
        logic        coast;     // No braking, coast
        logic        hold;      // Holding torque active
        logic [7:0]  hold_trq;  // Holding torque limit %
    } msh_drive_s;
    // Settings latched by configure
    typedef struct packed {
        logic dir_ccw;
        logic hold_en;
        logic two_wire;
    } msh_cfg_s;
endpackage

// file: src/msh_ramp.sv
// Speed ramp with optional softening filter
`timescale 1ns/100ps
`include "msh_defines.svh"
module msh_ramp
    import msh_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic [15:0] i_target,   // Requested speed
    input  wire logic [15:0] i_step_up,  // Accel step per cycle
    input  wire logic [15:0] i_step_dn,  // Decel step per cycle
    input  wire msh_filt_e   i_filt,     // Softening setting
    output logic      [15:0] o_speed     // Ramped speed
);
    logic [15:0] ramp_ff;      // Linear ramp value
    logic [15:0] filt_ff;      // Filtered ramp value
    logic [15:0] nxt_ramp;
    wire  [15:0] diff_up  = i_target - ramp_ff;
    wire  [15:0] diff_dn  = ramp_ff - i_target;
    wire  [3:0]  shift    = (i_filt == MSH_FILT2) ? 4'h4 : 4'h2;
    wire  [15:0] f_up     = (ramp_ff - filt_ff) >> shift;
    wire  [15:0] f_dn     = (filt_ff - ramp_ff) >> shift;
    // Linear step toward the target
    always_comb begin
        if (i_target > ramp_ff)
            nxt_ramp = (diff_up > i_step_up) ? ramp_ff + i_step_up : i_target;
        else
            nxt_ramp = (diff_dn > i_step_dn) ? ramp_ff - i_step_dn : i_target;
    end
    // Filter lags the ramp so edges soften; ramps take longer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ramp_ff <= 16'h0000;
            filt_ff <= 16'h0000;
        end else begin
            ramp_ff <= nxt_ramp;
            if (i_filt == MSH_FILT_OFF || filt_ff == ramp_ff)
                filt_ff <= ramp_ff;
            else if (ramp_ff > filt_ff)
                filt_ff <= filt_ff + ((f_up == 16'h0000) ? 16'h0001 : f_up);
            else
                filt_ff <= filt_ff - ((f_dn == 16'h0000) ? 16'h0001 : f_dn);
        end
    end
    assign o_speed = filt_ff;
endmodule

// file: src/msh_timer.sv
// Overload detection timer in tenths of a second
`timescale 1ns/100ps
`include "msh_defines.svh"
module msh_timer
    import msh_pkg::*;
#(
    parameter int unsigned TENTH_CYC = `MSH_TENTH_S_CYC
)(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_active,  // Overload condition present
    input  wire logic [7:0] i_limit,   // Detection time in tenths
    output logic            o_expired  // Held while time exceeded
);
    logic [31:0] sub_ff;   // Cycles within current tenth
    logic [7:0]  cnt_ff;   // Tenths elapsed
    // Clamp limit into 0.1 to 10.0 s; applied live
    wire  [7:0]  lim = (i_limit < `MSH_OVL_TENTHS_MIN) ? `MSH_OVL_TENTHS_MIN :
                       (i_limit > `MSH_OVL_TENTHS_MAX) ? `MSH_OVL_TENTHS_MAX : i_limit;
    wire         tick = (sub_ff == 32'(TENTH_CYC - 1));
    // Counts only while overloaded, restarts when cleared
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sub_ff <= 32'h0000_0000;
            cnt_ff <= 8'h00;
        end else if (!i_active) begin
            sub_ff <= 32'h0000_0000;
            cnt_ff <= 8'h00;
        end else begin
            sub_ff <= tick ? 32'h0000_0000 : sub_ff + 32'h0000_0001;
            if (tick && cnt_ff != 8'hFF)
                cnt_ff <= cnt_ff + 8'h01;
        end
    end
    assign o_expired = (cnt_ff >= lim);
endmodule

// file: sim/msh_motor_model.sv
// Behavioural motor and load that face the drive command
`timescale 1ns/100ps
module msh_motor_model
    import msh_pkg::*;
(
    input  wire logic        i_clk,
    input  wire msh_drive_s  i_drive,    // Drive command
    input  wire logic [15:0] i_offset,   // Speed error to inject
    input  wire logic [15:0] i_push_deg, // Load push on the shaft
    output logic      [15:0] o_meas,     // Measured speed
    output logic             o_coasting, // Free run slower than ramp
    output logic      [15:0] o_dev       // Shaft deviation
);
    // Rotor lags the command by a cycle, so the block never sees it early
    always_ff @(posedge i_clk) begin
        o_meas <= i_drive.speed + i_offset;
    end
    // A heavy load free-runs down more slowly than the ramp once released
    assign o_coasting = !i_drive.run;
    // Load deflects the shaft only while no run is commanded
    assign o_dev = i_drive.run ? 16'h0000 : i_push_deg;
endmodule

// file: sim/msh_ctrl_test.sv
// Self-checking bench for the motor stop and hold control block
`timescale 1ns/100ps
module msh_ctrl_test;
    import msh_pkg::*;
    typedef struct packed {logic [3:0] kind; logic [15:0] expv;} msh_note_s;
    logic        clk = 1'b0, rstn = 1'b0;
    logic        start = 1'b0, rdir = 1'b0, frun = 1'b0, dccw = 1'b0;
    logic        two = 1'b0, hen = 1'b0, ovl = 1'b0, aext = 1'b0, cfg = 1'b0;
    logic [15:0] cmd = 16'h0000, off = 16'h0000, wid = 16'h00C8, push = 16'h0000;
    logic [7:0]  hset = 8'hFF, oplim = 8'h00, otn = 8'h64;
    msh_stop_e   stp = MSH_STOP1;
    msh_filt_e   filt = MSH_FILT_OFF;
    logic        reach, alm, coast;
    logic [15:0] meas, dev, w;
    msh_drive_s  drv;
    msh_note_s   q[$];       // Expected results, oldest first
    msh_note_s   n;
    int          failures = 0, checks_done = 0, cyc = 0, seed = 50505;
    logic [7:0]  t_set[5] = '{8'hFF, 8'hFF, 8'h14, 8'h32, 8'h00};
    logic [7:0]  t_lim[5] = '{8'h1E, 8'h50, 8'h5A, 8'h0A, 8'h28};
    logic [7:0]  t_exp[5] = '{8'h1E, 8'h32, 8'h14, 8'h32, 8'h00};
    always #12.5 clk = ~clk;
    msh_ctrl #(.TENTH_CYC(10)) dut (.i_clk(clk), .i_rstn(rstn),
        .i_start_input(start), .i_run_direction_input(rdir),
        .i_forward_run_input(frun), .i_speed_cmd(cmd), .i_meas_speed(meas),
        .i_band_width(wid), .i_acc_step(16'hFFFF), .i_dec_step(16'hFFFF),
        .i_filt(filt), .i_stop_mode(stp), .i_dir_ccw(dccw),
        .i_two_wire(two), .i_hold_en(hen), .i_hold_trq_set(hset),
        .i_op_trq_lim(oplim), .i_shaft_dev_deg(dev), .i_coasting(coast),
        .i_overload(ovl), .i_ovl_tenths(otn), .i_alarm_ext(aext),
        .i_configure(cfg), .o_speed_reached_output(reach), .o_drive(drv),
        .o_alarm(alm));
    msh_motor_model motor (.i_clk(clk), .i_drive(drv), .i_offset(off),
        .i_push_deg(push), .o_meas(meas), .o_coasting(coast), .o_dev(dev));
    task automatic check_val(input logic [15:0] act, input logic [15:0] exp);
        checks_done++;
        if (act !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask
    task automatic check_bit(input logic act, input logic exp);
        check_val({15'h0000, act}, {15'h0000, exp});
    endtask
    task automatic note(input logic [3:0] k, input logic [15:0] e);
        q.push_back(msh_note_s'{k, e});
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic configure;
        cfg <= 1'b1;
        tick(1);
        cfg <= 1'b0;
        tick(2);
    endtask
    task test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watcher: at each falling edge take every note and compare it
    always @(negedge clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.kind)
                3'h0: check_bit(reach, n.expv[0]);
                3'h1: check_bit(drv.dir_ccw, n.expv[0]);
                3'h2: check_bit(drv.regen_ret, n.expv[0]);
                3'h3: check_bit(drv.coast, n.expv[0]);
                3'h4: check_bit(drv.hold, n.expv[0]);
                3'h5: check_val({8'h00, drv.hold_trq}, n.expv);
                3'h6: check_bit(alm, n.expv[0]);
                4'h8: check_bit(drv.speed == cmd, n.expv[0]);
                default: check_bit(drv.run, n.expv[0]);
            endcase
        end
    end
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        tick(10);
        note(3'h7, 16'h0000);
        note(3'h6, 16'h0000);
        rstn <= 1'b1;
        start <= 1'b1;
        cmd <= 16'h03E8;
        tick(30);
        note(3'h7, 16'h0001);
        note(4'h8, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            w = 16'(($random(seed) & 32'h7FFF_FFFF) % 400) + 16'h0001;
            wid <= w;
            off <= w;
            tick(4);
            note(3'h0, 16'h0001);
            off <= w + 16'h0001;
            tick(4);
            note(3'h0, 16'h0000);
            off <= 16'h0000 - w;
            tick(4);
            note(3'h0, 16'h0001);
            off <= 16'hFFFF - w;
            tick(4);
            note(3'h0, 16'h0000);
        end
        off <= 16'h0000;
        $display("speed band test done");
        dccw <= 1'b1;
        configure();
        rdir <= 1'b1;
        tick(3);
        note(3'h1, 16'h0001);
        rdir <= 1'b0;
        tick(3);
        note(3'h1, 16'h0000);
        dccw <= 1'b0;
        rdir <= 1'b1;
        tick(3);
        note(3'h1, 16'h0001);
        two <= 1'b1;
        rdir <= 1'b0;
        start <= 1'b0;
        configure();
        frun <= 1'b1;
        tick(3);
        note(3'h7, 16'h0001);
        note(3'h1, 16'h0000);
        frun <= 1'b0;
        rdir <= 1'b1;
        tick(3);
        note(3'h1, 16'h0001);
        rdir <= 1'b0;
        tick(3);
        note(3'h7, 16'h0000);
        $display("direction test done");
        for (int i = 0; i < 3; i++) begin
            stp <= msh_stop_e'(i);
            tick(3);
            note(3'h2, {15'h0000, i == 2});
            note(3'h3, {15'h0000, i == 1});
        end
        $display("stop method test done");
        hen <= 1'b1;
        configure();
        push <= 16'h000A;
        tick(3);
        note(3'h4, 16'h0000);
        push <= 16'h000F;
        hen <= 1'b0;
        tick(3);
        note(3'h4, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            hset <= t_set[i];
            oplim <= t_lim[i];
            tick(3);
            note(3'h5, {8'h00, t_exp[i]});
        end
        aext <= 1'b1;
        tick(3);
        note(3'h4, 16'h0000);
        note(3'h6, 16'h0001);
        aext <= 1'b0;
        $display("load holding test done");
        otn <= 8'h02;
        ovl <= 1'b1;
        tick(12);
        note(3'h6, 16'h0000);
        tick(12);
        note(3'h6, 16'h0001);
        ovl <= 1'b0;
        tick(3);
        note(3'h6, 16'h0000);
        $display("overload test done");
        // Filter picked while starting must wait for the next stop
        filt <= MSH_FILT1;
        frun <= 1'b1;
        tick(3);
        note(4'h8, 16'h0001);
        frun <= 1'b0;
        tick(4);
        frun <= 1'b1;
        tick(3);
        note(4'h8, 16'h0000);
        tick(40);
        note(4'h8, 16'h0001);
        frun <= 1'b0;
        $display("softening filter test done");
        tick(2);
        test_done();
    end
endmodule
